// *** core/awm_top.sv ***
// Application warning mask: source sync, command-driven enable mask,
// common masked warning output and AXI4-Lite register slave.
// Assumes warning sources arrive asynchronously from pins or other logic.
//
// Chosen here: the register offsets and the AXI4-Lite register port.

// What this block does
// (R1) Common warning output is high when any enabled source is active.
// (R2) Command code 0 leaves the mask unchanged.
// (R3) Command code 2 enables the listed group, mask reads 003F.
// (R4) Code 10 sets mask bit 0001 for the no-load warning.
// (R5) Codes 11 and 12 enable soft limit warnings at 0002 and 0004.
// (R6) Codes 13 and 14 enable hard limit warnings at 0008 and 0010.
// (R7) Code 15 enables the following deviation warning at 0020.
// (R8) Code 16 enables encoder warning 0040, only with a data track.
// (R9) Codes 17 and 18 enable user warnings at 0080 and 0100.
// (R10) Code 102 clears every mask bit.
// (R11) Codes 110 to 118 clear only the matching single bit.
// (R12) Mask is readable as one word of combined bit values.
// (R13) Raw warning states are reported regardless of the mask.
// (R14) Masked warning is selectable as source 215 for the digital output; the link always carries it.
// (R15) Each command changes the mask in one update, then it holds.
module awm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire awm_pkg::awm_src_s warn_src,
    input wire logic encoder_data_track,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic warning_link,
    output logic warning_dout
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Next mask for a command code; unknown codes leave the mask alone
    function automatic logic [8:0] apply_cmd(input logic [7:0] code, input logic [8:0] mask);
        logic [8:0] res;
        logic [7:0] idx;
        res = mask;
        idx = 8'h00;
        if (code == awm_pkg::CMD_NO_CHANGE) begin
            res = mask; // [R2]
        end else if (code == awm_pkg::CMD_ENABLE_ALL) begin
            res = awm_pkg::MASK_ALL_VALUE; // [R3]
        end else if (code >= awm_pkg::CMD_ENABLE_FIRST && code <= awm_pkg::CMD_ENABLE_LAST) begin
            idx = code - awm_pkg::CMD_ENABLE_FIRST;
            res[idx[3:0]] = 1'b1; // [R4] [R5] [R6] [R7] [R8] [R9]
        end else if (code == awm_pkg::CMD_DISABLE_ALL) begin
            res = awm_pkg::MASK_RESET; // [R10]
        end else if (code >= awm_pkg::CMD_DISABLE_FIRST && code <= awm_pkg::CMD_DISABLE_LAST) begin
            idx = code - awm_pkg::CMD_DISABLE_FIRST;
            res[idx[3:0]] = 1'b0; // [R11]
        end
        return res;
    endfunction

    // True for codes the command table knows
    function automatic logic known_cmd(input logic [7:0] code);
        logic ok;
        ok = (code == awm_pkg::CMD_NO_CHANGE) || (code == awm_pkg::CMD_ENABLE_ALL) ||
             (code == awm_pkg::CMD_DISABLE_ALL) ||
             (code >= awm_pkg::CMD_ENABLE_FIRST && code <= awm_pkg::CMD_ENABLE_LAST) ||
             (code >= awm_pkg::CMD_DISABLE_FIRST && code <= awm_pkg::CMD_DISABLE_LAST);
        return ok;
    endfunction

    // ************************************************************
    // Source synchroniser
    // ************************************************************
    logic [8:0] src_meta_ff;
    logic [8:0] src_sync_ff;
    logic track_meta_ff;
    logic track_sync_ff;
    logic [8:0] eff_src;
    logic [8:0] active;

    // Two stages; the first stage is read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_meta_ff <= 9'h000;
            src_sync_ff <= 9'h000;
            track_meta_ff <= 1'b0;
            track_sync_ff <= 1'b0;
        end else begin
            src_meta_ff <= warn_src;
            src_sync_ff <= src_meta_ff;
            track_meta_ff <= encoder_data_track;
            track_sync_ff <= track_meta_ff;
        end
    end

    // Encoder source is void without a data track
    always_comb begin
        eff_src = src_sync_ff;
        eff_src[6] = src_sync_ff[6] & track_sync_ff; // [R8]
    end

    // ************************************************************
    // Mask and warning output
    // ************************************************************
    logic [8:0] mask_ff;
    logic [7:0] last_cmd_ff;
    logic bad_cmd_ff;
    logic [7:0] route_ff;
    logic warn_ff;
    logic dout_ff;
    logic wr_go;
    logic [7:0] wr_addr_ff;
    logic [31:0] wr_data_ff;
    logic [3:0] wr_strb_ff;
    logic cmd_wr;
    logic route_wr;

    assign active = eff_src & mask_ff;
    assign cmd_wr = wr_go && (wr_addr_ff == awm_pkg::OFS_CMD) && wr_strb_ff[0];
    assign route_wr = wr_go && (wr_addr_ff == awm_pkg::OFS_ROUTE) && wr_strb_ff[0];

    // Mask changes only on a command write, all at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= awm_pkg::MASK_RESET;
            last_cmd_ff <= awm_pkg::CMD_NO_CHANGE;
            bad_cmd_ff <= 1'b0;
        end else if (cmd_wr) begin
            mask_ff <= apply_cmd(wr_data_ff[7:0], mask_ff); // [R15]
            last_cmd_ff <= wr_data_ff[7:0];
            bad_cmd_ff <= !known_cmd(wr_data_ff[7:0]);
        end
    end

    // Output source selector for the digital output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_ff <= awm_pkg::ROUTE_RESET;
        end else if (route_wr) begin
            route_ff <= wr_data_ff[7:0];
        end
    end

    // Registered outputs cost one cycle but keep the pins glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warn_ff <= 1'b0;
            dout_ff <= 1'b0;
        end else begin
            warn_ff <= |active; // [R1]
            dout_ff <= (route_ff == awm_pkg::SRC_MASKED_WARNING) && (|active); // [R14]
        end
    end

    assign warning_link = warn_ff;
    assign warning_dout = dout_ff;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic aw_held_ff;
    logic w_held_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic aw_take;
    logic w_take;
    logic wr_mapped;

    assign aw_take = s_axi_awvalid && awready_ff;
    assign w_take = s_axi_wvalid && wready_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_mapped = (wr_addr_ff == awm_pkg::OFS_CMD) || (wr_addr_ff == awm_pkg::OFS_MASK) ||
                       (wr_addr_ff == awm_pkg::OFS_RAW) || (wr_addr_ff == awm_pkg::OFS_STATUS) ||
                       (wr_addr_ff == awm_pkg::OFS_ROUTE);

    // Address and data are taken in either order and held until used
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        if (wr_go) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
        end
        if (aw_take) begin
            nxt_aw_held = 1'b1;
        end
        if (w_take) begin
            nxt_w_held = 1'b1;
        end
    end

    // Holding flags and ready flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= !nxt_aw_held;
            wready_ff <= !nxt_w_held;
        end
    end

    // Captured payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 32'h0000_0000;
            wr_strb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                wr_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                wr_data_ff <= s_axi_wdata;
                wr_strb_ff <= s_axi_wstrb;
            end
        end
    end

    // Response; read-only words ignore writes, unmapped ones answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= awm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? awm_pkg::RESP_OKAY : awm_pkg::RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic nxt_rvalid;
    logic ar_take;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    assign ar_take = s_axi_arvalid && arready_ff;

    // Read decode; unused bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = awm_pkg::RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            awm_pkg::OFS_CMD: begin
                rd_word[7:0] = last_cmd_ff;
            end
            awm_pkg::OFS_MASK: begin
                rd_word[8:0] = mask_ff; // [R12]
            end
            awm_pkg::OFS_RAW: begin
                rd_word[8:0] = src_sync_ff; // [R13]
            end
            awm_pkg::OFS_STATUS: begin
                rd_word[awm_pkg::STS_WARN_BIT] = warn_ff;
                rd_word[awm_pkg::STS_BADCMD_BIT] = bad_cmd_ff;
                rd_word[awm_pkg::STS_ACTIVE_LSB +: 9] = active;
            end
            awm_pkg::OFS_ROUTE: begin
                rd_word[7:0] = route_ff;
            end
            default: begin
                rd_resp = awm_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        if (ar_take) begin
            nxt_rvalid = 1'b1;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // One read in flight; data frozen while rvalid stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= awm_pkg::RESP_OKAY;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_resp;
            end
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule

// *** core/awm_pkg.sv ***
// Constants and types shared by the application warning mask block.
// Assumes one 10 MHz clock and an AXI4-Lite master on the register side.
package awm_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int MASK_W = 9;
    localparam int CODE_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_RAW = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_ROUTE = 8'h10;

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int STS_WARN_BIT = 0;
    localparam int STS_BADCMD_BIT = 1;
    localparam int STS_ACTIVE_LSB = 16;

    // ************************************************************
    // Command codes and mask values
    // ************************************************************
    localparam logic [7:0] CMD_NO_CHANGE = 8'h00;
    localparam logic [7:0] CMD_ENABLE_ALL = 8'h02;
    localparam logic [7:0] CMD_ENABLE_FIRST = 8'h0A;
    localparam logic [7:0] CMD_ENABLE_LAST = 8'h12;
    localparam logic [7:0] CMD_DISABLE_ALL = 8'h66;
    localparam logic [7:0] CMD_DISABLE_FIRST = 8'h6E;
    localparam logic [7:0] CMD_DISABLE_LAST = 8'h76;
    localparam logic [8:0] MASK_ALL_VALUE = 9'h03F;
    localparam logic [8:0] MASK_RESET = 9'h000;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [7:0] SRC_MASKED_WARNING = 8'hD7;

    // ************************************************************
    // AXI responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Warning sources, bit 8 first
    typedef struct packed {
        logic user_warning_2;
        logic user_warning_1;
        logic encoder_warning;
        logic following_deviation_warning;
        logic hard_limit_negative_warning;
        logic hard_limit_positive_warning;
        logic soft_limit_negative_warning;
        logic soft_limit_positive_warning;
        logic no_load_warning;
    } awm_src_s;

endpackage

// *** tb/awm_top_monitor.sv ***
// Checker for the warning mask block: bus answers and warning outputs.
// Assumes it is bound into awm_top and sees only that module's ports.
module awm_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire awm_pkg::awm_src_s warn_src,
    input wire logic encoder_data_track,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic warning_link,
    input wire logic warning_dout
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Only the encoder source, with no data track, long enough to pass the sync
    sequence s_enc_alone;
        (warn_src == 9'h040 && !encoder_data_track) [*4];
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_link_quiet: assert property ((warn_src == 9'h000) [*4] |=> !warning_link)
        else $error("warning without source");
    a_enc_gated: assert property (s_enc_alone |=> !warning_link)
        else $error("encoder warning without data track");
    a_dout_link: assert property (warning_dout |-> warning_link)
        else $error("output warning without link warning");
    a_link_cause: assert property ($rose(warning_link) |->
        ($past(warn_src, 2) | $past(warn_src, 3) | $past(warn_src, 4)) != 9'h000)
        else $error("warning rose with no recent source");
endmodule

bind awm_top awm_top_monitor u_mon (.aclk, .aresetn, .warn_src, .encoder_data_track, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .warning_link, .warning_dout);

// *** tb/application_warning_mask_test.sv ***
// Self-checking bench for the warning mask block over AXI4-Lite.
// Assumes awm_pkg, awm_top and the bound monitor are compiled before it.
module application_warning_mask_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, encoder_data_track, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic warning_link, warning_dout;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    awm_pkg::awm_src_s warn_src;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_fail = 0;
    int n_compared = 0;

    awm_top DUT (.aclk, .aresetn, .warn_src, .encoder_data_track, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .warning_link, .warning_dout);

    // ************************************************************
    // Clock, comparison and bus tasks
    // ************************************************************
    always #50 aclk = ~aclk;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One write or read; the expected answer is noted before the request
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        logic done;
        done = 1'b0;
        @(posedge aclk);
        if (wr) begin
            bq.push_back(r);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            rq.push_back({r, d});
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) begin
            n_fail++;
            print_verdict();
        end
    endtask

    // Answers are compared against the oldest note at the handshake edge
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int c;
        logic [8:0] m, s, v;
        aclk = 1'b0;
        aresetn = 1'b0;
        warn_src = '0;
        encoder_data_track = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'h19989357));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // Reset contents, then an unmapped word
        bus(0, awm_pkg::OFS_MASK, 32'h0, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_ROUTE, 32'h0, awm_pkg::RESP_OKAY);
        bus(0, 8'h14, 32'h0, awm_pkg::RESP_SLVERR);
        // Every enable code adds its own bit
        m = 9'h000;
        for (c = 10; c <= 18; c++) begin
            m[c - 10] = 1'b1;
            bus(1, awm_pkg::OFS_CMD, 32'(c), awm_pkg::RESP_OKAY);
            bus(0, awm_pkg::OFS_MASK, {23'h0, m}, awm_pkg::RESP_OKAY);
        end
        bus(1, awm_pkg::OFS_CMD, 32'h0, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_MASK, 32'h1FF, awm_pkg::RESP_OKAY);
        // Every disable code drops only its own bit
        for (c = 110; c <= 118; c++) begin
            m[c - 110] = 1'b0;
            bus(1, awm_pkg::OFS_CMD, 32'(c), awm_pkg::RESP_OKAY);
            bus(0, awm_pkg::OFS_MASK, {23'h0, m}, awm_pkg::RESP_OKAY);
        end
        // An unknown code is flagged and leaves the mask alone
        bus(1, awm_pkg::OFS_CMD, 32'h05, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_STATUS, 32'h2, awm_pkg::RESP_OKAY);
        // Writes that must not touch the mask: read-only word, unmapped word, byte 0 not strobed
        bus(1, awm_pkg::OFS_MASK, 32'h1FF, awm_pkg::RESP_OKAY);
        bus(1, 8'h14, 32'h02, awm_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        bus(1, awm_pkg::OFS_CMD, 32'h02, awm_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        bus(0, awm_pkg::OFS_MASK, 32'h0, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_CMD, 32'h05, awm_pkg::RESP_OKAY);
        bus(1, awm_pkg::OFS_CMD, 32'h02, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_MASK, 32'h03F, awm_pkg::RESP_OKAY);
        bus(1, awm_pkg::OFS_CMD, 32'h10, awm_pkg::RESP_OKAY);
        bus(1, awm_pkg::OFS_ROUTE, 32'hD7, awm_pkg::RESP_OKAY);
        bus(0, awm_pkg::OFS_ROUTE, 32'hD7, awm_pkg::RESP_OKAY);
        // Random sources against mask 07F; four edges cover the sync stages
        for (c = 0; c < 16; c++) begin
            @(posedge aclk);
            s = 9'($urandom);
            warn_src <= s;
            encoder_data_track <= 1'($urandom);
            repeat (4) @(posedge aclk);
            v = s & 9'h07F & (encoder_data_track ? 9'h1FF : 9'h1BF);
            check({33'h0, warning_link}, {33'h0, |v});
            check({33'h0, warning_dout}, {33'h0, |v});
            bus(0, awm_pkg::OFS_RAW, {23'h0, s}, awm_pkg::RESP_OKAY);
            bus(0, awm_pkg::OFS_STATUS, {7'h0, v, 15'h0, |v}, awm_pkg::RESP_OKAY);
        end
        // Another route source silences the digital output only
        @(posedge aclk);
        warn_src <= 9'h001;
        bus(1, awm_pkg::OFS_ROUTE, 32'hD6, awm_pkg::RESP_OKAY);
        repeat (4) @(posedge aclk);
        check({33'h0, warning_dout}, 34'h0);
        check({33'h0, warning_link}, 34'h1);
        // Encoder source counts only with a data track
        warn_src <= 9'h040;
        encoder_data_track <= 1'b0;
        repeat (5) @(posedge aclk);
        check({33'h0, warning_link}, 34'h0);
        encoder_data_track <= 1'b1;
        repeat (5) @(posedge aclk);
        check({33'h0, warning_link}, 34'h1);
        bus(1, awm_pkg::OFS_CMD, 32'h66, awm_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        check({33'h0, warning_link}, 34'h0);
        bus(0, awm_pkg::OFS_MASK, 32'h0, awm_pkg::RESP_OKAY);
        print_verdict();
    end
endmodule
